// file: rtl/vfs_defines.svh
// Timing figures, counts and reset values of the fault supervisor
`ifndef VFS_DEFINES_SVH
`define VFS_DEFINES_SVH

// Core clock
`define VFS_CLK_PERIOD_NS        5
// Switching cycle, 500 kHz nominal
`define VFS_SWITCH_PERIOD_NS     2000
`define VFS_SWITCH_DIV           (`VFS_SWITCH_PERIOD_NS / `VFS_CLK_PERIOD_NS)
// Ready delay after the final target is reached, longest time rounds down
`define VFS_READY_DELAY_NS       85000
`define VFS_READY_DELAY_CYCLES   (`VFS_READY_DELAY_NS / `VFS_CLK_PERIOD_NS)
// Hiccup wait in switching cycles
`define VFS_HICCUP_SWITCH_CYCLES 4096
// Per-channel persistence in switching cycles
`define VFS_CHAN_OC_CYCLES       8
// Fault reaction budget and the pipeline spent on it
`define VFS_FAULT_REACT_NS       20
`define VFS_FAULT_REACT_CYCLES   (`VFS_FAULT_REACT_NS / `VFS_CLK_PERIOD_NS)
// Channel count and counter widths
`define VFS_CHANNELS             4
`define VFS_CHAN_CNT_W           4
`define VFS_READY_CNT_W          16
`define VFS_HICCUP_CNT_W         13
`define VFS_DIV_CNT_W            12
// Number of pin inputs through the synchronisers
`define VFS_SYNC_W               15
// Reset values
`define VFS_RST_SYNC             15'h0000
`define VFS_RST_CHAN_CNT         4'h0

`endif

// file: rtl/vfs_pkg.sv
// Types shared by the fault supervisor modules
package vfs_pkg;

  typedef enum logic [2:0] {
    VFS_SHUTDOWN    = 3'b000,
    VFS_SOFT_START  = 3'b001,
    VFS_READY_DELAY = 3'b010,
    VFS_READY       = 3'b011,
    VFS_HICCUP      = 3'b100
  } vfs_state_t;

endpackage

// file: rtl/vfs_ocp_if.sv
// Signals between the supervisor and the per-channel overcurrent counters
`timescale 1ns/100ps
`include "vfs_defines.svh"

interface vfs_ocp_if;
  logic                       switchTick;
  logic                       clearCounters;
  logic [`VFS_CHANNELS-1:0]   chanOver;
  logic [`VFS_CHANNELS-1:0]   chanTrip;

  modport supervisor (output switchTick, output clearCounters, output chanOver,
                      input chanTrip);
  modport counter    (input switchTick, input clearCounters, input chanOver,
                      output chanTrip);
endinterface

// file: rtl/vfs_ocp_counter.sv
// Per-channel sustained overcurrent persistence counters
`timescale 1ns/100ps
`include "vfs_defines.svh"

module vfs_ocp_counter (
  input  wire logic  clock,
  input  wire logic  resetn,
  vfs_ocp_if.counter ocp
);

  genvar ch;
  generate
    for (ch = 0; ch < `VFS_CHANNELS; ch = ch + 1) begin : gChan
      logic [`VFS_CHAN_CNT_W-1:0] count_reg;
      logic [`VFS_CHAN_CNT_W-1:0] count_next;
      wire                        atLimit;

      assign atLimit = (count_reg == `VFS_CHAN_CNT_W'(`VFS_CHAN_OC_CYCLES));

      // R12: consecutive cycles
      // R19: restart at or below
      always_comb begin
        count_next = count_reg;
        if (ocp.clearCounters) begin
          count_next = `VFS_RST_CHAN_CNT;
        end else if (ocp.switchTick) begin
          if (!ocp.chanOver[ch]) begin
            count_next = `VFS_RST_CHAN_CNT;
          end else if (!atLimit) begin
            count_next = count_reg + `VFS_CHAN_CNT_W'(1);
          end
        end
      end

      always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
          count_reg <= `VFS_RST_CHAN_CNT;
        end else begin
          count_reg <= count_next;
        end
      end

      // R12: eight cycles trip
      assign ocp.chanTrip[ch] = atLimit;
    end
  endgenerate

endmodule // vfs_ocp_counter

// file: rtl/vfs_supervisor.sv
// Fault supervisor and power-good logic of a multiphase buck controller
//
// Summary of operation
// R01: Power-good held low in shutdown; released after soft-start plus ready delay.
// R02: Power-good low on undervoltage, overvoltage, disable, reset or VOLTAGE_ID_CODE off code.
// R03: Output sense below half the VOLTAGE_ID_CODE target is undervoltage; power-good low.
// R04: Overvoltage guard active from reset release, enabled or not.
// R05: Before VOLTAGE_ID_CODE is valid, overvoltage threshold is the fixed 1.275 V.
// R06: After valid VOLTAGE_ID_CODE, overvoltage trip point becomes VOLTAGE_ID_CODE plus 175 mV.
// R07: Overvoltage forces PWM low within 20 ns until sense below 0.4 V, then high-Z.
// R08: Each recurring overvoltage forces PWM low again, repeating the sequence.
// R09: After overvoltage, normal switching stops until enable or supply cycling.
// R10: VOLTAGE_ID_CODE code changes never clear the latched overvoltage state.
// R11: Average current above reference trips overcurrent shutdown at once.
// R12: Any channel above reference for eight switching cycles trips shutdown.
// R13: Overcurrent puts PWM high-Z within 20 ns for 4096 switching cycles.
// R14: After the wait, restart soft-start if enabled; retry indefinitely.
// R15: Fan request and overtemperature alert are open-drain outputs.
// R16: Fan request released below 33 percent, pulled low above 39 percent.
// R17: Overtemperature alert released below 28 percent, low above 33 percent.
// R18: Ready delay between final target and power-good is 85 microseconds.
// R19: Channel persistence counter restarts when current is at or below reference.
// R20: Hiccup counter counts switching cycles; cleared on disable or reset.
`timescale 1ns/100ps
`include "vfs_defines.svh"

module vfs_supervisor #(
  parameter int unsigned READY_DELAY_CYCLES = `VFS_READY_DELAY_CYCLES,
  parameter int unsigned SWITCH_DIV         = `VFS_SWITCH_DIV,
  parameter int unsigned HICCUP_CYCLES      = `VFS_HICCUP_SWITCH_CYCLES
) (
  input  wire logic                     clock,
  input  wire logic                     resetn,
  // Pin and comparator inputs, asynchronous to clock
  input  wire logic                     porOkIn,
  input  wire logic                     power_rail_enable_in,
  input  wire logic                     termination_rail_enable_in,
  input  wire logic                     ovAboveFixedIn,
  input  wire logic                     ovAboveVidIn,
  input  wire logic                     output_sense_in,
  input  wire logic                     differential_output_sense,
  input  wire logic                     average_sense_current,
  input  wire logic [`VFS_CHANNELS-1:0] chanOverIn,
  input  wire logic                     tempBelow28In,
  input  wire logic                     tempBelow33In,
  input  wire logic                     tempBelow39In,
  // Same-domain status from the soft-start and VOLTAGE_ID_CODE logic
  input  wire logic                     softStartDoneIn,
  input  wire logic                     voltage_id_code,
  input  wire logic                     vidOffCodeIn,
  // PWM drive state, soft-start restart pulse and overvoltage status
  output logic                          pwmEnableOut,
  output logic                          pwmForceLowOut,
  output logic                          pwmHighZOut,
  output logic                          softStartRestartOut,
  output logic                          ovThresholdVidSelOut,
  output logic                          overvoltage_guard,
  // Open-drain indicators
  output logic                          power_good_out,
  output logic                          powerGoodOe,
  output logic                          fan_request_out,
  output logic                          fanRequestOe,
  output logic                          overtemp_alert_out,
  output logic                          overtempAlertOe
);

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers

  wire  [`VFS_SYNC_W-1:0] asyncIn;
  logic [`VFS_SYNC_W-1:0] syncA_reg;
  logic [`VFS_SYNC_W-1:0] syncB_reg;

  assign asyncIn = {tempBelow39In, tempBelow33In, tempBelow28In, chanOverIn,
                    average_sense_current, differential_output_sense,
                    output_sense_in, ovAboveVidIn, ovAboveFixedIn,
                    termination_rail_enable_in, power_rail_enable_in, porOkIn};

  genvar b;
  generate
    for (b = 0; b < `VFS_SYNC_W; b = b + 1) begin : gSync
      always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
          syncA_reg[b] <= 1'b0;
          syncB_reg[b] <= 1'b0;
        end else begin
          syncA_reg[b] <= asyncIn[b];
          syncB_reg[b] <= syncA_reg[b];
        end
      end
    end
  endgenerate

  wire                     porOk     = syncB_reg[0];
  wire                     railEn    = syncB_reg[1];
  wire                     termEn    = syncB_reg[2];
  wire                     ovFixed   = syncB_reg[3];
  wire                     ovVid     = syncB_reg[4];
  wire                     underVolt = syncB_reg[5];
  wire                     diffLow   = syncB_reg[6];
  wire                     avgOver   = syncB_reg[7];
  wire [`VFS_CHANNELS-1:0] chanOver  = syncB_reg[11:8];
  wire                     below28   = syncB_reg[12];
  wire                     below33   = syncB_reg[13];
  wire                     below39   = syncB_reg[14];

  ////////////////////////////////////////////////////////////////////////////
  // Enable chain and latched shutdown causes

  logic vidOff_reg;
  logic vidSel_reg;
  logic ovLatched_reg;
  logic ovDriveLow_reg;

  // Supply or either enable dropping is the only way out of a latched fault
  wire hardReset = !porOk || !railEn || !termEn;
  wire disabled  = hardReset || vidOff_reg;

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      vidOff_reg <= 1'b0;
    end else if (hardReset) begin
      vidOff_reg <= 1'b0;
    end else if (vidOffCodeIn) begin
      vidOff_reg <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Overvoltage guard

  // R05: fixed threshold until VOLTAGE_ID_CODE valid
  // R06: VOLTAGE_ID_CODE-based trip point
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      vidSel_reg <= 1'b0;
    end else if (disabled) begin
      vidSel_reg <= 1'b0;
    end else if (voltage_id_code) begin
      vidSel_reg <= 1'b1;
    end
  end

  // R04: guard live after reset
  wire ovTrip = porOk && (vidSel_reg ? ovVid : ovFixed);

  // R09: latch until enable cycling
  // R10: VOLTAGE_ID_CODE never clears it
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      ovLatched_reg <= 1'b0;
    end else if (ovTrip) begin
      ovLatched_reg <= 1'b1;
    end else if (hardReset) begin
      ovLatched_reg <= 1'b0;
    end
  end

  // R07: low until sense under 0.4 V
  // R08: recurrence drives low again
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      ovDriveLow_reg <= 1'b0;
    end else if (ovTrip) begin
      ovDriveLow_reg <= 1'b1;
    end else if (diffLow) begin
      ovDriveLow_reg <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Switching-cycle divider and channel counters

  logic [`VFS_DIV_CNT_W-1:0] div_reg;
  wire                       switchTick = (div_reg == `VFS_DIV_CNT_W'(SWITCH_DIV - 1));

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      div_reg <= '0;
    end else if (switchTick) begin
      div_reg <= '0;
    end else begin
      div_reg <= div_reg + `VFS_DIV_CNT_W'(1);
    end
  end

  vfs_ocp_if ocpBus ();

  assign ocpBus.switchTick    = switchTick;
  assign ocpBus.clearCounters = disabled;
  assign ocpBus.chanOver      = chanOver;

  vfs_ocp_counter uOcpCounter (
    .clock  (clock),
    .resetn (resetn),
    .ocp    (ocpBus.counter)
  );

  // R11: average trips at once
  // R12: persistent channel trips
  wire ocTrip = avgOver || (|ocpBus.chanTrip);

  ////////////////////////////////////////////////////////////////////////////
  // Sequencing state machine

  vfs_pkg::vfs_state_t           state_reg;
  vfs_pkg::vfs_state_t           state_next;
  logic [`VFS_READY_CNT_W-1:0]   readyCnt_reg;
  logic [`VFS_HICCUP_CNT_W-1:0]  hiccupCnt_reg;
  logic                          restart_reg;

  wire running   = (state_reg == vfs_pkg::VFS_SOFT_START) ||
                   (state_reg == vfs_pkg::VFS_READY_DELAY) ||
                   (state_reg == vfs_pkg::VFS_READY);
  wire readyDone = (readyCnt_reg == `VFS_READY_CNT_W'(READY_DELAY_CYCLES - 1));
  wire hiccupEnd = switchTick &&
                   (hiccupCnt_reg == `VFS_HICCUP_CNT_W'(HICCUP_CYCLES - 1));

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      vfs_pkg::VFS_SHUTDOWN: begin
        state_next = vfs_pkg::VFS_SOFT_START;
      end
      vfs_pkg::VFS_SOFT_START: begin
        if (softStartDoneIn) begin
          state_next = vfs_pkg::VFS_READY_DELAY;
        end
      end
      vfs_pkg::VFS_READY_DELAY: begin
        // R18: 85 us ready delay
        if (readyDone) begin
          state_next = vfs_pkg::VFS_READY;
        end
      end
      vfs_pkg::VFS_READY: begin
        state_next = vfs_pkg::VFS_READY;
      end
      vfs_pkg::VFS_HICCUP: begin
        // R14: retry soft-start
        if (hiccupEnd) begin
          state_next = vfs_pkg::VFS_SOFT_START;
        end
      end
      default: begin
        state_next = vfs_pkg::VFS_SHUTDOWN;
      end
    endcase
    // R13: overcurrent enters hiccup
    if (running && ocTrip) begin
      state_next = vfs_pkg::VFS_HICCUP;
    end
    if (disabled) begin
      state_next = vfs_pkg::VFS_SHUTDOWN;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      state_reg <= vfs_pkg::VFS_SHUTDOWN;
    end else begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      readyCnt_reg <= '0;
    end else if (state_reg != vfs_pkg::VFS_READY_DELAY) begin
      readyCnt_reg <= '0;
    end else if (!readyDone) begin
      readyCnt_reg <= readyCnt_reg + `VFS_READY_CNT_W'(1);
    end
  end

  // R20: counts ticks, cleared on disable
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      hiccupCnt_reg <= '0;
    end else if (disabled || state_reg != vfs_pkg::VFS_HICCUP) begin
      hiccupCnt_reg <= '0;
    end else if (switchTick) begin
      hiccupCnt_reg <= hiccupCnt_reg + `VFS_HICCUP_CNT_W'(1);
    end
  end

  // One-cycle pulse when soft-start is (re)launched
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      restart_reg <= 1'b0;
    end else begin
      restart_reg <= (state_next == vfs_pkg::VFS_SOFT_START) &&
                     (state_reg != vfs_pkg::VFS_SOFT_START);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Thermal hysteresis

  logic fanRelease_reg;
  logic hotRelease_reg;

  // R16: fan 33 / 39 percent
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      fanRelease_reg <= 1'b0;
    end else if (below33) begin
      fanRelease_reg <= 1'b1;
    end else if (!below39) begin
      fanRelease_reg <= 1'b0;
    end
  end

  // R17: alert 28 / 33 percent
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      hotRelease_reg <= 1'b0;
    end else if (below28) begin
      hotRelease_reg <= 1'b1;
    end else if (!below33) begin
      hotRelease_reg <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  logic pgRelease_reg;
  logic pwmEnable_reg;
  logic pwmLow_reg;
  logic pwmHighZ_reg;

  // R01: release only when ready
  // R02: any fault or disable pulls low
  // R03: undervoltage pulls low
  wire pgReleaseNext = (state_reg == vfs_pkg::VFS_READY) && !disabled &&
                       !underVolt && !ovTrip && !ovLatched_reg;

  // Driver state is registered once; sync plus this flop stays inside 20 ns
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      pgRelease_reg <= 1'b0;
      pwmEnable_reg <= 1'b0;
      pwmLow_reg    <= 1'b0;
      pwmHighZ_reg  <= 1'b1;
    end else begin
      pgRelease_reg <= pgReleaseNext;
      // R09: no switching after overvoltage
      pwmEnable_reg <= running && !ocTrip && !disabled && !ovLatched_reg && !ovTrip;
      // R07: low on overvoltage
      pwmLow_reg    <= ovTrip || ovDriveLow_reg;
      // R13: high-Z on overcurrent
      pwmHighZ_reg  <= !(ovTrip || ovDriveLow_reg) &&
                       (!running || ocTrip || disabled || ovLatched_reg);
    end
  end

  assign pwmEnableOut         = pwmEnable_reg;
  assign pwmForceLowOut       = pwmLow_reg;
  assign pwmHighZOut          = pwmHighZ_reg;
  assign softStartRestartOut  = restart_reg;
  assign ovThresholdVidSelOut = vidSel_reg;
  assign overvoltage_guard    = ovLatched_reg;

  // R15: open-drain, low only
  assign power_good_out       = 1'b0;
  assign powerGoodOe          = !pgRelease_reg;
  assign fan_request_out      = 1'b0;
  assign fanRequestOe         = !fanRelease_reg;
  assign overtemp_alert_out   = 1'b0;
  assign overtempAlertOe      = !hotRelease_reg;

endmodule // vfs_supervisor

// file: tb/vfs_board_model.sv
// Board-side model: pull-ups on the open-drain pins and the MOSFET driver response
`timescale 1ns/100ps

module vfs_board_model (
  input  wire logic       powerGoodOe,
  input  wire logic       fanRequestOe,
  input  wire logic       overtempAlertOe,
  input  wire logic       pwmForceLowOut,
  input  wire logic       pwmHighZOut,
  output logic            powerGoodPin,
  output logic            fanPin,
  output logic            hotPin,
  output logic [1:0]      driverMode
);
  ////////////////////////////////////////////////////////////////////////////////
  // pull-up resolution
  assign powerGoodPin = powerGoodOe ? 1'b0 : 1'b1;
  assign fanPin       = fanRequestOe ? 1'b0 : 1'b1;
  assign hotPin       = overtempAlertOe ? 1'b0 : 1'b1;
  ////////////////////////////////////////////////////////////////////////////////
  // driver: 1 = low side on, 2 = both off, 0 = switching
  assign driverMode   = pwmForceLowOut ? 2'h1 : (pwmHighZOut ? 2'h2 : 2'h0);
endmodule // vfs_board_model

// file: tb/vfs_supervisor_chk.sv
// Port-level assertions of the fault supervisor
`timescale 1ns/100ps

module vfs_supervisor_chk #(
  parameter int unsigned READY_DELAY_CYCLES = 20,
  parameter int unsigned SWITCH_DIV         = 4,
  parameter int unsigned HICCUP_CYCLES      = 3
) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic porOkIn,
  input wire logic power_rail_enable_in,
  input wire logic termination_rail_enable_in,
  input wire logic ovAboveFixedIn,
  input wire logic output_sense_in,
  input wire logic average_sense_current,
  input wire logic tempBelow28In,
  input wire logic tempBelow33In,
  input wire logic tempBelow39In,
  input wire logic softStartDoneIn,
  input wire logic pwmEnableOut,
  input wire logic pwmForceLowOut,
  input wire logic pwmHighZOut,
  input wire logic softStartRestartOut,
  input wire logic ovThresholdVidSelOut,
  input wire logic overvoltage_guard,
  input wire logic power_good_out,
  input wire logic powerGoodOe,
  input wire logic fan_request_out,
  input wire logic fanRequestOe,
  input wire logic overtemp_alert_out,
  input wire logic overtempAlertOe
);
  // One switching tick of slack for the unknown divider phase
  localparam int HOLD_MIN = (HICCUP_CYCLES - 1) * SWITCH_DIV;
  int   onCnt, doneCnt, ocCnt;
  logic ocRun, ocNext, enPrev, allOn;
  assign allOn  = porOkIn & power_rail_enable_in & termination_rail_enable_in;
  assign ocNext = allOn & pwmHighZOut & !softStartRestartOut & (ocRun | (enPrev & (onCnt >= 4)));
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      onCnt   <= 0;
      doneCnt <= 0;
      ocCnt   <= 0;
      ocRun   <= 1'b0;
      enPrev  <= 1'b0;
    end else begin
      onCnt   <= allOn ? onCnt + 1 : 0;
      doneCnt <= softStartDoneIn ? doneCnt + 1 : 0;
      ocCnt   <= ocRun ? ocCnt + 1 : 0;
      ocRun   <= ocNext;
      enPrev  <= pwmEnableOut;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  default clocking dcb @(posedge clock); endclocking
  default disable iff (!resetn);
  sequence sqDrainEnd;
    pwmForceLowOut ##1 !pwmForceLowOut;
  endsequence
  AST_OV_ACT: assert property (porOkIn && $past(porOkIn, 3) && !ovThresholdVidSelOut
    && $rose(ovAboveFixedIn) |-> ##[1:4] (pwmForceLowOut && overvoltage_guard))
    else $error("ov slow");
  AST_OV_PG: assert property (overvoltage_guard && $past(overvoltage_guard)
    |-> powerGoodOe && !pwmEnableOut) else $error("ov pg");
  AST_OV_FLOAT: assert property (sqDrainEnd |-> pwmHighZOut)
    else $error("ov float");
  AST_OV_LATCH: assert property (overvoltage_guard && onCnt >= 4 |=> overvoltage_guard)
    else $error("ov latch");
  AST_OC_TRIP: assert property (pwmEnableOut && $rose(average_sense_current)
    |-> ##[1:4] pwmHighZOut) else $error("oc slow");
  AST_HICCUP_HOLD: assert property (softStartRestartOut && ocRun |-> ocCnt >= HOLD_MIN)
    else $error("hiccup short");
  AST_PG_DELAY: assert property ($fell(powerGoodOe) |-> doneCnt >= READY_DELAY_CYCLES)
    else $error("pg early");
  AST_PG_UV: assert property (output_sense_in [*4] |-> powerGoodOe)
    else $error("pg uv");
  AST_PG_OFF: assert property (!power_rail_enable_in [*4]
    |-> powerGoodOe && !ovThresholdVidSelOut) else $error("pg off");
  AST_FAN_REL: assert property (tempBelow33In [*4] |-> !fanRequestOe)
    else $error("fan rel");
  AST_FAN_PULL: assert property (!tempBelow39In [*4] |-> fanRequestOe)
    else $error("fan pull");
  AST_HOT_REL: assert property (tempBelow28In [*4] |-> !overtempAlertOe)
    else $error("hot rel");
  AST_HOT_PULL: assert property (!tempBelow33In [*4] |-> overtempAlertOe)
    else $error("hot pull");
  AST_OD_LOW: assert property (!power_good_out && !fan_request_out && !overtemp_alert_out)
    else $error("od data");
endmodule // vfs_supervisor_chk

bind vfs_supervisor vfs_supervisor_chk #(.READY_DELAY_CYCLES(READY_DELAY_CYCLES),
  .SWITCH_DIV(SWITCH_DIV), .HICCUP_CYCLES(HICCUP_CYCLES)) vfs_supervisor_chk_i (
  .clock, .resetn, .porOkIn, .power_rail_enable_in, .termination_rail_enable_in,
  .ovAboveFixedIn, .output_sense_in, .average_sense_current, .tempBelow28In,
  .tempBelow33In, .tempBelow39In, .softStartDoneIn, .pwmEnableOut, .pwmForceLowOut,
  .pwmHighZOut, .softStartRestartOut, .ovThresholdVidSelOut, .overvoltage_guard,
  .power_good_out, .powerGoodOe, .fan_request_out, .fanRequestOe, .overtemp_alert_out,
  .overtempAlertOe);

// file: tb/testbench.sv
// Self-checking testbench of the fault supervisor
`timescale 1ns/100ps
`include "vfs_defines.svh"

module testbench;
  localparam int RDC = 20, DIV = 4, HIC = 3;
  logic clock, resetn, porOkIn, power_rail_enable_in, termination_rail_enable_in;
  logic ovAboveFixedIn, ovAboveVidIn, output_sense_in, differential_output_sense;
  logic average_sense_current, tempBelow28In, tempBelow33In, tempBelow39In;
  logic softStartDoneIn, voltage_id_code, vidOffCodeIn;
  logic [`VFS_CHANNELS-1:0] chanOverIn;
  logic pwmEnableOut, pwmForceLowOut, pwmHighZOut, softStartRestartOut;
  logic ovThresholdVidSelOut, overvoltage_guard, power_good_out, powerGoodOe;
  logic fan_request_out, fanRequestOe, overtemp_alert_out, overtempAlertOe;
  logic powerGoodPin, fanPin, hotPin;
  logic [1:0] driverMode;
  int   errTotal, checksDone, cycles;

  vfs_supervisor #(.READY_DELAY_CYCLES(RDC), .SWITCH_DIV(DIV), .HICCUP_CYCLES(HIC))
  vfs_supervisor_i (.clock, .resetn, .porOkIn, .power_rail_enable_in,
    .termination_rail_enable_in, .ovAboveFixedIn, .ovAboveVidIn, .output_sense_in,
    .differential_output_sense, .average_sense_current, .chanOverIn, .tempBelow28In,
    .tempBelow33In, .tempBelow39In, .softStartDoneIn, .voltage_id_code, .vidOffCodeIn,
    .pwmEnableOut, .pwmForceLowOut, .pwmHighZOut, .softStartRestartOut,
    .ovThresholdVidSelOut, .overvoltage_guard, .power_good_out, .powerGoodOe,
    .fan_request_out, .fanRequestOe, .overtemp_alert_out, .overtempAlertOe);
  vfs_board_model vfs_board_model_i (.powerGoodOe, .fanRequestOe, .overtempAlertOe,
    .pwmForceLowOut, .pwmHighZOut, .powerGoodPin, .fanPin, .hotPin, .driverMode);
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  // Whole sequence needs under 2000 cycles
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      errTotal++;
      stopTest();
    end
  end
  task automatic stopTest();
    $display("checks %0d, mismatches %0d", checksDone, errTotal);
    if (errTotal == 0 && checksDone > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input string what, input logic exp, input logic got);
    checksDone++;
    if (got !== exp) begin
      errTotal++;
      $display("unexpected %s: expected %b, seen %b", what, exp, got);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clock);
  endtask
  task automatic waitRestart(output int n);
    n = 0;
    while (softStartRestartOut !== 1'b1 && n < 60) begin
      @(posedge clock);
      #1;
      n++;
    end
    chk("retry", 1'b1, softStartRestartOut);
    @(negedge clock);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic overVoltageIdle();
    porOkIn = 1'b1;
    ovAboveVidIn = 1'b1;
    cyc(4);
    chk("ov vid idle", 1'b0, overvoltage_guard);
    ovAboveVidIn = 1'b0;
    ovAboveFixedIn = 1'b1;
    cyc(4);
    chk("ov idle", 1'b1, overvoltage_guard);
    chk("drain idle", 1'b1, driverMode == 2'h1);
    ovAboveFixedIn = 1'b0;
    differential_output_sense = 1'b1;
    porOkIn = 1'b0;
    cyc(4);
    chk("ov por", 1'b0, overvoltage_guard);
    chk("float idle", 1'b1, driverMode == 2'h2);
    differential_output_sense = 1'b0;
  endtask
  task automatic powerUp();
    porOkIn = 1'b1;
    {power_rail_enable_in, termination_rail_enable_in, voltage_id_code} = 3'h7;
    cyc(3);
    chk("pg start", 1'b0, powerGoodPin);
    softStartDoneIn = 1'b1;
    cyc(RDC);
    chk("pg early", 1'b0, powerGoodPin);
    cyc(3);
    chk("pg ready", 1'b1, powerGoodPin);
    chk("vid sel", 1'b1, ovThresholdVidSelOut);
  endtask
  task automatic thermal();
    logic [2:0] lv [6] = '{3'h3, 3'h1, 3'h0, 3'h1, 3'h3, 3'h7};
    logic [5:0] fanExp = 6'h33;
    logic [5:0] hotExp = 6'h21;
    for (int i = 0; i < 6; i++) begin
      {tempBelow28In, tempBelow33In, tempBelow39In} = lv[i];
      cyc(3);
      chk("fan", fanExp[5-i], fanPin);
      chk("hot", hotExp[5-i], hotPin);
    end
  endtask
  task automatic underVoltage();
    output_sense_in = 1'b1;
    cyc(3);
    chk("pg uv", 1'b0, powerGoodPin);
    output_sense_in = 1'b0;
    cyc(3);
  endtask
  task automatic overCurrentChan();
    int n;
    chanOverIn = 4'h4;
    cyc(7 * DIV);
    chanOverIn = 4'h0;
    cyc(2 * DIV);
    chanOverIn = 4'h4;
    cyc(7 * DIV);
    chk("oc 7", 1'b0, pwmHighZOut);
    cyc(DIV + 3);
    chk("oc 8", 1'b1, pwmHighZOut);
    chanOverIn = 4'h0;
    waitRestart(n);
    cyc(RDC + 6);
  endtask
  task automatic overCurrentAvg();
    int n;
    average_sense_current = 1'b1;
    cyc(3);
    chk("oc float", 1'b1, driverMode == 2'h2);
    waitRestart(n);
    chk("hiccup", 1'b1, n >= (HIC - 1) * DIV && n <= HIC * DIV + 3);
    waitRestart(n);
    average_sense_current = 1'b0;
    cyc(6);
    if (pwmHighZOut === 1'b1) waitRestart(n);
    cyc(RDC + 6);
    chk("pg retry", 1'b1, powerGoodPin);
  endtask
  task automatic overVoltage();
    ovAboveVidIn = 1'b1;
    cyc(4);
    chk("ov low", 1'b1, driverMode == 2'h1);
    chk("pg ov", 1'b0, powerGoodPin);
    ovAboveVidIn = 1'b0;
    differential_output_sense = 1'b1;
    cyc(4);
    chk("ov float", 1'b1, driverMode == 2'h2);
    differential_output_sense = 1'b0;
    ovAboveVidIn = 1'b1;
    cyc(4);
    chk("ov again", 1'b1, pwmForceLowOut);
    ovAboveVidIn = 1'b0;
    differential_output_sense = 1'b1;
    voltage_id_code = 1'b0;
    cyc(3);
    voltage_id_code = 1'b1;
    cyc(3);
    chk("ov vid", 1'b1, overvoltage_guard);
    chk("ov pwm", 1'b0, pwmEnableOut);
    termination_rail_enable_in = 1'b0;
    cyc(4);
    termination_rail_enable_in = 1'b1;
    cyc(4);
    chk("ov en", 1'b0, overvoltage_guard);
    cyc(RDC + 6);
    power_rail_enable_in = 1'b0;
    cyc(4);
    chk("pg off", 1'b0, powerGoodPin);
    power_rail_enable_in = 1'b1;
    cyc(RDC + 6);
    vidOffCodeIn = 1'b1;
    cyc(3);
    chk("pg vid off", 1'b0, powerGoodPin);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    resetn = 1'b0;
    {porOkIn, power_rail_enable_in, termination_rail_enable_in, ovAboveFixedIn, ovAboveVidIn,
     output_sense_in, differential_output_sense, average_sense_current, softStartDoneIn,
     voltage_id_code, vidOffCodeIn} = 11'h000;
    {tempBelow28In, tempBelow33In, tempBelow39In} = 3'h7;
    chanOverIn = 4'h0;
    cyc(5);
    resetn = 1'b1;
    overVoltageIdle();
    powerUp();
    thermal();
    underVoltage();
    overCurrentChan();
    overCurrentAvg();
    overVoltage();
    stopTest();
  end
endmodule // testbench
